//--- ccc_map.svh
// register map and timing counts of the coulomb count core
// Contract
// - discharge: discharge count per pulse, time counter per tick.
// - charge: charge count per pulse, time counter per tick.
// - time counters 16 bits, wrap past ffff, then set slow bit.
// - time counters step per 0.8789 s, per 225 s when slow.
// - self-discharge hourly at 25 C, doubling per 10 C to 60 C.
// - self-discharge halves per 10 C below 25 C, floor 0 C.
// - offset adds periodic counts to charge or discharge count.
// - regulator disable bit turns the regulator amplifier off.
// - regulator stays on in sleep unless disabled.
// - host commands sleep, counter reset, flash program, flash copy.
// - block program, erase within 1520 us; byte program within 90 us.
// - response starts 190 to 320 us after a read request.
// - any line low is a bit start; host keeps glitches off.
// - clearing a time counter clears its slow bit.
// - one to a clear bit zeroes that counter; bit self-clears.
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH

`define CCC_CLK_MHZ 20
`define CCC_TIME_TICK_US 878900
`define CCC_TIME_TICK_CYC (`CCC_TIME_TICK_US * `CCC_CLK_MHZ)
`define CCC_SLOW_DIV_MAX 8'hFF
`define CCC_OFF_LSB_US 9760
`define CCC_OFF_LSB_CYC (`CCC_OFF_LSB_US * `CCC_CLK_MHZ)
`define CCC_BLOCK_US 1520
`define CCC_BLOCK_CYC (`CCC_BLOCK_US * `CCC_CLK_MHZ)
`define CCC_BYTE_US 90
`define CCC_BYTE_CYC (`CCC_BYTE_US * `CCC_CLK_MHZ)
`define CCC_RESP_US 200
`define CCC_RESP_CYC (`CCC_RESP_US * `CCC_CLK_MHZ)
`define CCC_SD_WRAP 17'h0_8000

`define CCC_A_CHG 5'h00
`define CCC_A_DIS 5'h01
`define CCC_A_SELF 5'h02
`define CCC_A_CTIME 5'h03
`define CCC_A_DTIME 5'h04
`define CCC_A_MODE 5'h05
`define CCC_A_CLR 5'h06
`define CCC_A_OFFLO 5'h07
`define CCC_A_OFFHI 5'h08
`define CCC_A_CMD 5'h09
`define CCC_A_IRQST 5'h0A
`define CCC_A_IRQMSK 5'h0B

`define CCC_MODE_CSLOW 0
`define CCC_MODE_DSLOW 1
`define CCC_MODE_REGDIS 2
`define CCC_MODE_SLEEP 3

`define CCC_CLR_CHG 0
`define CCC_CLR_DIS 1
`define CCC_CLR_SELF 2
`define CCC_CLR_CTIME 3
`define CCC_CLR_DTIME 4

`define CCC_OFFHI_CHGOFF 4
`define CCC_OFFHI_COMPEN 5

`define CCC_IRQ_ROLLC 0
`define CCC_IRQ_ROLLD 1
`define CCC_IRQ_DONE 2
`define CCC_IRQ_WAKE 3

`define CCC_FLASH_RST 16'hFFFF
`define CCC_LINE_RST 4'h8

`endif

//--- ccc_pkg.sv
// types of the coulomb count core
package ccc_pkg;

    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_SLEEP = 3'h1,
        CMD_RSTCNT = 3'h2,
        CMD_PROG = 3'h3,
        CMD_LOAD = 3'h4,
        CMD_BYTE = 3'h5,
        CMD_ERASE = 3'h6
    } ccc_cmd_t;

    typedef enum logic [1:0] {
        FL_IDLE = 2'h0,
        FL_BYTE = 2'h1,
        FL_BLOCK = 2'h3,
        FL_ERASE = 2'h2
    } ccc_flash_t;

endpackage : ccc_pkg

//--- ccc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ccc_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_LEVEL = '0
) (
    input wire logic clk, // core clock
    input wire logic rst_b, // async reset
    input wire logic [WIDTH-1:0] pinIn, // raw pins
    output logic [WIDTH-1:0] levelOut // filtered levels
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : gBit
            logic [2:0] stage_reg;
            logic lvl_reg;
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    stage_reg <= {3{RST_LEVEL[g]}};
                else
                    stage_reg <= {stage_reg[1:0], pinIn[g]};
            end
            // change taken once second and third stage agree
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    lvl_reg <= RST_LEVEL[g];
                else if (stage_reg[1] == stage_reg[2])
                    lvl_reg <= stage_reg[2];
            end
            assign levelOut[g] = lvl_reg;
        end
    endgenerate

endmodule : ccc_pin_sync

//--- ccc_coulomb_count_core.sv
// coulomb count core: charge counters, timers, offset, flash commands
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "ccc_map.svh"
module ccc_coulomb_count_core #(
    parameter int unsigned TIME_TICK_CYC = `CCC_TIME_TICK_CYC,
    parameter int unsigned OFF_LSB_CYC = `CCC_OFF_LSB_CYC,
    parameter int unsigned BLOCK_CYC = `CCC_BLOCK_CYC
) (
    input wire logic clk, // core clock
    input wire logic rst_b, // async reset
    input wire logic [4:0] regAddr, // register address
    input wire logic [15:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [15:0] regRdata, // read data
    input wire logic pulsePin, // converter pulse pin
    input wire logic [1:0] sensePolarity, // 01 charge, 10 discharge
    input wire logic linePin, // line level
    input wire logic hostReadDone, // read request ended
    input wire logic signed [7:0] tempC, // die temperature
    output logic irq, // interrupt
    output logic regulatorOn, // regulator enable
    output logic sleepMode, // low-power state
    output logic linkBitStart, // bit start seen
    output logic linkRespStart // response may start
);

    logic [3:0] syncLvl;
    logic pulsePrev_reg, linePrev_reg;
    logic pulseEdge, lineFall, lineChange, chgAct, dchgAct, awake;
    logic [31:0] tickCnt_reg;
    logic tick;
    logic [4:0] clrPend_reg;
    logic rstCnt_reg;
    logic [4:0] clrVec;
    logic [15:0] chgCnt_reg, disCnt_reg, sdCnt_reg;
    logic [16:0] sdAcc_reg;
    logic [16:0] sdSum;
    logic [15:0] offLo_reg;
    logic [5:0] offHi_reg;
    logic [19:0] offVal, offUnits_reg;
    logic [31:0] offLsb_reg;
    logic offLsbTick, compPulse;
    logic regDis_reg, regulatorOn_reg, sleep_reg;
    logic [1:0] actT, clrT, stepT, rollEv;
    logic [15:0] timeCnt_reg [2];
    logic [7:0] slowPre_reg [2];
    logic slow_reg [2];
    logic [15:0] ram_reg [8];
    logic [15:0] flash_reg [8];
    ccc_pkg::ccc_flash_t flState_reg;
    logic [15:0] busyCnt_reg;
    logic [2:0] byteIdx_reg;
    logic flDone, cmdWr, loadCmd;
    ccc_pkg::ccc_cmd_t cmdCode;
    logic [3:0] irqSt_reg, irqMask_reg, irqEv;
    logic irq_reg;
    logic [11:0] respCnt_reg;
    logic respStart_reg, bitStart_reg;
    logic [15:0] readMux, regRdata_reg;

    ccc_pin_sync #(
        .WIDTH(4),
        .RST_LEVEL(`CCC_LINE_RST)
    ) u_sync (
        .clk,
        .rst_b,
        .pinIn({linePin, sensePolarity, pulsePin}),
        .levelOut(syncLvl)
    );

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pulsePrev_reg <= 1'b0;
            linePrev_reg <= 1'b1;
        end
        else
        begin
            pulsePrev_reg <= syncLvl[0];
            linePrev_reg <= syncLvl[3];
        end
    end

    assign pulseEdge = syncLvl[0] & ~pulsePrev_reg;
    assign lineFall = linePrev_reg & ~syncLvl[3];
    assign lineChange = linePrev_reg ^ syncLvl[3];
    assign chgAct = (syncLvl[2:1] == 2'b01);
    assign dchgAct = (syncLvl[2:1] == 2'b10);
    assign awake = ~sleep_reg;

    // base tick, one per 0.8789 s
    assign tick = (tickCnt_reg == 32'(TIME_TICK_CYC - 1));
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            tickCnt_reg <= 32'h0000_0000;
        else if (tick)
            tickCnt_reg <= 32'h0000_0000;
        else
            tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
    end

    // clear bits live one cycle, then drop back
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            clrPend_reg <= 5'h00;
        else if (regWr && regAddr == `CCC_A_CLR)
            clrPend_reg <= regWdata[4:0];
        else
            clrPend_reg <= 5'h00;
    end
    assign clrVec = clrPend_reg | {5{rstCnt_reg}};

    // time counters, index 0 charge, 1 discharge
    assign actT = {dchgAct, chgAct} & {2{awake}};
    assign clrT = {clrVec[`CCC_CLR_DTIME], clrVec[`CCC_CLR_CTIME]};
    genvar t;
    generate
        for (t = 0; t < 2; t++)
        begin : gTime
            assign stepT[t] = tick & actT[t] & (~slow_reg[t] |
                (slowPre_reg[t] == `CCC_SLOW_DIV_MAX));
            assign rollEv[t] = stepT[t] & (timeCnt_reg[t] == 16'hFFFF);
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    timeCnt_reg[t] <= 16'h0000;
                else if (clrT[t])
                    timeCnt_reg[t] <= 16'h0000;
                else if (stepT[t])
                    timeCnt_reg[t] <= timeCnt_reg[t] + 16'h0001;
            end
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    slow_reg[t] <= 1'b0;
                else if (clrT[t])
                    slow_reg[t] <= 1'b0;
                else if (rollEv[t])
                    slow_reg[t] <= 1'b1;
            end
            // divides ticks by 256 while slow
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    slowPre_reg[t] <= 8'h00;
                else if (clrT[t])
                    slowPre_reg[t] <= 8'h00;
                else if (tick && actT[t] && slow_reg[t])
                    slowPre_reg[t] <= slowPre_reg[t] + 8'h01;
            end
        end
    endgenerate

    // offset compensation period in 9.76 ms units
    assign offVal = {offHi_reg[3:0], offLo_reg};
    assign offLsbTick = (offLsb_reg == 32'(OFF_LSB_CYC - 1));
    assign compPulse = offLsbTick && (offUnits_reg == offVal - 20'h0_0001);
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            offLsb_reg <= 32'h0000_0000;
            offUnits_reg <= 20'h0_0000;
        end
        else if (!offHi_reg[`CCC_OFFHI_COMPEN] || offVal == 20'h0_0000 || !awake)
        begin
            offLsb_reg <= 32'h0000_0000;
            offUnits_reg <= 20'h0_0000;
        end
        else if (offLsbTick)
        begin
            offLsb_reg <= 32'h0000_0000;
            offUnits_reg <= compPulse ? 20'h0_0000 : offUnits_reg + 20'h0_0001;
        end
        else
            offLsb_reg <= offLsb_reg + 32'h0000_0001;
    end

    // charge and discharge count registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            chgCnt_reg <= 16'h0000;
        else if (clrVec[`CCC_CLR_CHG])
            chgCnt_reg <= 16'h0000;
        else if (chgAct && awake)
            chgCnt_reg <= chgCnt_reg + 16'({1'b0, pulseEdge} + {1'b0, compPulse &
                ~offHi_reg[`CCC_OFFHI_CHGOFF]});
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            disCnt_reg <= 16'h0000;
        else if (clrVec[`CCC_CLR_DIS])
            disCnt_reg <= 16'h0000;
        else if (dchgAct && awake)
            disCnt_reg <= disCnt_reg + 16'({1'b0, pulseEdge} + {1'b0, compPulse &
                offHi_reg[`CCC_OFFHI_CHGOFF]});
    end

    // ticks weighted by temperature band, 8 at 25 C, 4096 ticks per hour
    function automatic logic [6:0] sdWeight(input logic signed [7:0] tc);
        if (tc >= 8'sh37)
            sdWeight = 7'h40;
        else if (tc >= 8'sh2D)
            sdWeight = 7'h20;
        else if (tc >= 8'sh23)
            sdWeight = 7'h10;
        else if (tc >= 8'sh19)
            sdWeight = 7'h08;
        else if (tc >= 8'sh0F)
            sdWeight = 7'h04;
        else if (tc >= 8'sh05)
            sdWeight = 7'h02;
        else
            sdWeight = 7'h01;
    endfunction : sdWeight

    assign sdSum = sdAcc_reg + 17'(sdWeight(tempC));
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sdAcc_reg <= 17'h0_0000;
            sdCnt_reg <= 16'h0000;
        end
        else if (clrVec[`CCC_CLR_SELF])
        begin
            sdAcc_reg <= 17'h0_0000;
            sdCnt_reg <= 16'h0000;
        end
        else if (tick && sdSum >= `CCC_SD_WRAP)
        begin
            sdAcc_reg <= sdSum - `CCC_SD_WRAP;
            sdCnt_reg <= sdCnt_reg + 16'h0001;
        end
        else if (tick)
            sdAcc_reg <= sdSum;
    end

    // control registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regDis_reg <= 1'b0;
            offLo_reg <= 16'h0000;
            offHi_reg <= 6'h00;
            irqMask_reg <= 4'h0;
        end
        else if (regWr)
        begin
            if (regAddr == `CCC_A_MODE)
                regDis_reg <= regWdata[`CCC_MODE_REGDIS];
            if (regAddr == `CCC_A_OFFLO)
                offLo_reg <= regWdata;
            if (regAddr == `CCC_A_OFFHI)
                offHi_reg <= regWdata[5:0];
            if (regAddr == `CCC_A_IRQMSK)
                irqMask_reg <= regWdata[3:0];
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            regulatorOn_reg <= 1'b1;
        else
            regulatorOn_reg <= ~regDis_reg;
    end

    // command decode, refused while flash busy
    assign cmdCode = ccc_pkg::ccc_cmd_t'(regWdata[2:0]);
    assign cmdWr = regWr && regAddr == `CCC_A_CMD && flState_reg == ccc_pkg::FL_IDLE;
    assign loadCmd = cmdWr && cmdCode == ccc_pkg::CMD_LOAD;
    assign flDone = flState_reg != ccc_pkg::FL_IDLE && busyCnt_reg == 16'h0000;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rstCnt_reg <= 1'b0;
        else
            rstCnt_reg <= cmdWr && cmdCode == ccc_pkg::CMD_RSTCNT;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sleep_reg <= 1'b0;
        else if (cmdWr && cmdCode == ccc_pkg::CMD_SLEEP)
            sleep_reg <= 1'b1;
        else if (lineChange)
            sleep_reg <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flState_reg <= ccc_pkg::FL_IDLE;
            busyCnt_reg <= 16'h0000;
            byteIdx_reg <= 3'h0;
        end
        else
        begin
            unique case (flState_reg)
                ccc_pkg::FL_IDLE:
                begin
                    if (cmdWr && cmdCode == ccc_pkg::CMD_PROG)
                    begin
                        flState_reg <= ccc_pkg::FL_BLOCK;
                        busyCnt_reg <= 16'(BLOCK_CYC - 1);
                    end
                    else if (cmdWr && cmdCode == ccc_pkg::CMD_ERASE)
                    begin
                        flState_reg <= ccc_pkg::FL_ERASE;
                        busyCnt_reg <= 16'(BLOCK_CYC - 1);
                    end
                    else if (cmdWr && cmdCode == ccc_pkg::CMD_BYTE)
                    begin
                        flState_reg <= ccc_pkg::FL_BYTE;
                        busyCnt_reg <= 16'(`CCC_BYTE_CYC - 1);
                        byteIdx_reg <= regWdata[10:8];
                    end
                end
                ccc_pkg::FL_BYTE, ccc_pkg::FL_BLOCK, ccc_pkg::FL_ERASE:
                begin
                    if (flDone)
                        flState_reg <= ccc_pkg::FL_IDLE;
                    else
                        busyCnt_reg <= busyCnt_reg - 16'h0001;
                end
            endcase
        end
    end

    genvar m;
    generate
        for (m = 0; m < 8; m++)
        begin : gMem
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    ram_reg[m] <= 16'h0000;
                else if (loadCmd)
                    ram_reg[m] <= flash_reg[m];
                else if (regWr && regAddr == {2'b10, 3'(m)})
                    ram_reg[m] <= regWdata;
            end
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    flash_reg[m] <= `CCC_FLASH_RST;
                else if (flDone && flState_reg == ccc_pkg::FL_ERASE)
                    flash_reg[m] <= `CCC_FLASH_RST;
                else if (flDone && (flState_reg == ccc_pkg::FL_BLOCK ||
                    byteIdx_reg == 3'(m)))
                    flash_reg[m] <= ram_reg[m];
            end
        end
    endgenerate

    // line bit start and delayed response start
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            respCnt_reg <= 12'h000;
        else if (hostReadDone)
            respCnt_reg <= 12'(`CCC_RESP_CYC);
        else if (respCnt_reg != 12'h000)
            respCnt_reg <= respCnt_reg - 12'h001;
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            respStart_reg <= 1'b0;
            bitStart_reg <= 1'b0;
        end
        else
        begin
            respStart_reg <= respCnt_reg == 12'h001 && !hostReadDone;
            bitStart_reg <= lineFall;
        end
    end

    // sticky status, set wins over write-one clear
    assign irqEv[`CCC_IRQ_ROLLC] = rollEv[0];
    assign irqEv[`CCC_IRQ_ROLLD] = rollEv[1];
    assign irqEv[`CCC_IRQ_DONE] = flDone;
    assign irqEv[`CCC_IRQ_WAKE] = sleep_reg & lineChange;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irqSt_reg <= 4'h0;
        else if (regWr && regAddr == `CCC_A_IRQST)
            irqSt_reg <= (irqSt_reg & ~regWdata[3:0]) | irqEv;
        else
            irqSt_reg <= irqSt_reg | irqEv;
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(irqSt_reg & irqMask_reg);
    end

    always_comb
    begin
        readMux = 16'h0000;
        if (regAddr[4])
            readMux = regAddr[3] ? flash_reg[regAddr[2:0]] : ram_reg[regAddr[2:0]];
        else
        begin
            case (regAddr)
                `CCC_A_CHG: readMux = chgCnt_reg;
                `CCC_A_DIS: readMux = disCnt_reg;
                `CCC_A_SELF: readMux = sdCnt_reg;
                `CCC_A_CTIME: readMux = timeCnt_reg[0];
                `CCC_A_DTIME: readMux = timeCnt_reg[1];
                `CCC_A_MODE:
                begin
                    readMux[`CCC_MODE_CSLOW] = slow_reg[0];
                    readMux[`CCC_MODE_DSLOW] = slow_reg[1];
                    readMux[`CCC_MODE_REGDIS] = regDis_reg;
                    readMux[`CCC_MODE_SLEEP] = sleep_reg;
                end
                `CCC_A_CLR: readMux = {11'h000, clrPend_reg};
                `CCC_A_OFFLO: readMux = offLo_reg;
                `CCC_A_OFFHI: readMux = {10'h000, offHi_reg};
                `CCC_A_CMD: readMux = {15'h0000, flState_reg != ccc_pkg::FL_IDLE};
                `CCC_A_IRQST: readMux = {12'h000, irqSt_reg};
                `CCC_A_IRQMSK: readMux = {12'h000, irqMask_reg};
                default: readMux = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            regRdata_reg <= 16'h0000;
        else
            regRdata_reg <= regRd ? readMux : 16'h0000;
    end

    assign regRdata = regRdata_reg;
    assign irq = irq_reg;
    assign regulatorOn = regulatorOn_reg;
    assign sleepMode = sleep_reg;
    assign linkBitStart = bitStart_reg;
    assign linkRespStart = respStart_reg;

endmodule : ccc_coulomb_count_core

//--- ccc_core_monitor.sv
// port-level assertion checker for the coulomb count core
`timescale 1ns/1ps
module ccc_core_monitor (
    input wire logic clk, // clock
    input wire logic rst_b, // reset
    input wire logic [4:0] regAddr, // address
    input wire logic [15:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    input wire logic [15:0] regRdata, // read data
    input wire logic linePin, // line level
    input wire logic hostReadDone, // read request ended
    input wire logic regulatorOn, // regulator enable
    input wire logic sleepMode, // sleep state
    input wire logic linkBitStart, // bit start
    input wire logic linkRespStart // response start
);
    logic [12:0] respCnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // cycles since read request
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            respCnt <= '0;
        else if (hostReadDone)
            respCnt <= 13'h0001;
        else if (respCnt == 13'h0FA1)
            respCnt <= '0;
        else if (respCnt != '0)
            respCnt <= respCnt + 13'h0001;
    end
    a_resp_not_early: assert property (
        linkRespStart |-> respCnt == 13'h0FA1) else $error("resp early");
    a_resp_on_time: assert property (
        respCnt == 13'h0FA1 |-> linkRespStart) else $error("resp late");
    a_resp_one_cycle: assert property (
        linkRespStart |=> !linkRespStart) else $error("resp long");
    a_read_idle_zero: assert property (
        !$past(regRd) |-> regRdata == 16'h0000) else $error("rdata idle");
    a_regulator_follows: assert property (
        regWr && regAddr == 5'h05 |=> ##1 regulatorOn == !$past(regWdata[2], 2))
        else $error("reg enable");
    a_sleep_entry: assert property (
        regWr && regAddr == 5'h09 && regWdata[2:0] == 3'h1 |-> ##[1:2] sleepMode)
        else $error("no sleep");
    a_bit_start_seen: assert property (
        $fell(linePin) ##1 !linePin [*3] |-> ##[0:3] linkBitStart)
        else $error("no bit start");
    a_bit_start_pulse: assert property (
        linkBitStart |=> !linkBitStart) else $error("bit start long");
endmodule : ccc_core_monitor

bind ccc_coulomb_count_core ccc_core_monitor mon (.clk, .rst_b, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .linePin, .hostReadDone, .regulatorOn, .sleepMode,
    .linkBitStart, .linkRespStart);

//--- ccc_host_model.sv
// host model: line lows and read requests
`timescale 1ns/1ps
module ccc_host_model (
    input wire logic clk, // core clock
    output logic linePin, // line level, idle high
    output logic hostReadDone // read request ended
);
    initial
    begin
        linePin = 1'b1;
        hostReadDone = 1'b0;
    end
    // whole-cycle lows only, never a glitch
    task line_low(input int n);
        @(posedge clk);
        linePin <= 1'b0;
        repeat (n) @(posedge clk);
        linePin <= 1'b1;
    endtask : line_low
    task read_req();
        @(posedge clk);
        hostReadDone <= 1'b1;
        @(posedge clk);
        hostReadDone <= 1'b0;
    endtask : read_req
endmodule : ccc_host_model

//--- testbench.sv
// self-checking bench for the coulomb count core
`timescale 1ns/1ps
module testbench;
    logic clk, rst_b, regWr, regRd, pulsePin, linePin, hostReadDone;
    logic [4:0] regAddr;
    logic [15:0] regWdata, regRdata, d;
    logic [1:0] sensePolarity;
    logic signed [7:0] tempC;
    logic irq, regulatorOn, sleepMode, linkBitStart, linkRespStart;
    int n_errors, n_compared, cyc, n;
    ccc_coulomb_count_core #(.TIME_TICK_CYC(20), .OFF_LSB_CYC(4), .BLOCK_CYC(50)) uut (
        .clk, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .pulsePin,
        .sensePolarity, .linePin, .hostReadDone, .tempC, .irq, .regulatorOn, .sleepMode,
        .linkBitStart, .linkRespStart);
    ccc_host_model host (.clk, .linePin, .hostReadDone);
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task rd(input logic [4:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    task rdc(input string nm, input logic [4:0] a, input logic [15:0] e);
        rd(a);
        chk(nm, e, d);
    endtask : rdc
    task pulses(input int k);
        repeat (k)
        begin
            @(posedge clk) pulsePin <= 1'b1;
            repeat (6) @(posedge clk);
            pulsePin <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask : pulses
    task pol(input logic [1:0] p);
        @(posedge clk) sensePolarity <= p;
        repeat (8) @(posedge clk);
    endtask : pol
    task busy_polls();
        n = 0;
        do
        begin
            rd(5'h09);
            n++;
        end while (d[0] === 1'b1 && n < 2000);
    endtask : busy_polls
    task t_count();
        rdc("mode", 5'h05, 16'h0000);
        chk("regon", 16'h0001, 16'(regulatorOn));
        rdc("unmap", 5'h0C, 16'h0000);
        pol(2'b01);
        wr(5'h06, 16'h0003);
        pulses(3);
        rdc("chg", 5'h00, 16'h0003);
        rdc("dis", 5'h01, 16'h0000);
        pol(2'b10);
        pulses(2);
        rdc("dis", 5'h01, 16'h0002);
        pol(2'b00);
        pulses(2);
        rdc("chg0", 5'h00, 16'h0003);
        rd(5'h03);
        repeat (100) @(posedge clk);
        rdc("ctime0", 5'h03, d);
        pol(2'b10);
        wr(5'h06, 16'h0010);
        repeat (200) @(posedge clk);
        rd(5'h04);
        chk("drate", 16'h0001, 16'(d >= 16'd9 && d <= 16'd11));
    endtask : t_count
    task t_clear();
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= 5'h06;
        regWdata <= 16'h0010;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk("clrpend", 16'h0010, regRdata);
        rdc("clrdone", 5'h06, 16'h0000);
        rd(5'h04);
        chk("dzero", 16'h0001, 16'(d <= 16'd1));
    endtask : t_clear
    task t_offset();
        pol(2'b01);
        wr(5'h07, 16'h0005);
        wr(5'h08, 16'h0020);
        wr(5'h06, 16'h0001);
        repeat (200) @(posedge clk);
        wr(5'h08, 16'h0000);
        rd(5'h00);
        chk("offset", 16'h0001, 16'(d >= 16'd9 && d <= 16'd11));
    endtask : t_offset
    task t_sleep();
        wr(5'h05, 16'h0004);
        repeat (2) @(posedge clk);
        chk("regoff", 16'h0000, 16'(regulatorOn));
        wr(5'h05, 16'h0000);
        wr(5'h0B, 16'h0008);
        wr(5'h09, 16'h0001);
        repeat (2) @(posedge clk);
        chk("sleep", 16'h0001, 16'(sleepMode));
        chk("regsleep", 16'h0001, 16'(regulatorOn));
        host.line_low(6);
        repeat (6) @(posedge clk);
        chk("wake", 16'h0000, 16'(sleepMode));
        rdc("irqst", 5'h0A, 16'h0008);
        chk("irqon", 16'h0001, 16'(irq));
        wr(5'h0B, 16'h0000);
        repeat (2) @(posedge clk);
        chk("irqmask", 16'h0000, 16'(irq));
        wr(5'h0B, 16'h0008);
        wr(5'h0A, 16'h0008);
        repeat (2) @(posedge clk);
        chk("irqclr", 16'h0000, 16'(irq));
    endtask : t_sleep
    task t_flash();
        wr(5'h09, 16'h0002);
        rdc("rstcnt", 5'h00, 16'h0000);
        wr(5'h10, 16'h1234);
        wr(5'h11, 16'h00A5);
        wr(5'h09, 16'h0006);
        busy_polls();
        chk("erase_t", 16'h0001, 16'(n >= 24 && n <= 28));
        rdc("erased", 5'h18, 16'hFFFF);
        wr(5'h09, 16'h0003);
        busy_polls();
        rdc("prog", 5'h18, 16'h1234);
        wr(5'h10, 16'h0000);
        wr(5'h09, 16'h0004);
        rdc("load", 5'h10, 16'h1234);
        wr(5'h09, 16'h0105);
        busy_polls();
        chk("byte_t", 16'h0001, 16'(n >= 895 && n <= 902));
        rdc("byte", 5'h19, 16'h00A5);
        rdc("done", 5'h0A, 16'h0004);
    endtask : t_flash
    task t_link();
        host.read_req();
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end while (linkRespStart !== 1'b1 && n < 5000);
        chk("resp", 16'd4000, n[15:0]);
    endtask : t_link
    task t_scr();
        @(posedge clk) tempC <= 8'sd60;
        wr(5'h06, 16'h0004);
        repeat (21000) @(posedge clk);
        rdc("self", 5'h02, 16'h0002);
    endtask : t_scr
    task tally_and_finish();
        $display("checks %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        {n_errors, n_compared, cyc} = '0;
        {rst_b, regWr, regRd, pulsePin, regAddr, regWdata, sensePolarity} = '0;
        tempC = 8'sd0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_count();
        t_clear();
        t_offset();
        t_sleep();
        t_flash();
        t_link();
        t_scr();
        tally_and_finish();
    end
endmodule : testbench
